// ==== hdl/tnmc_timer.v ====
// Overview of operation
// - stay_awake_in_standby keeps the timer running while standby sleep is active.
// - prescale_select codes 0..7 tick at clock divided by 1,2,4,8,16,64,256,1024.
// - main control bit 0 enables the timer; zero keeps it stopped.
// - pin-override bits 4..6 put waveforms on pins in PWM and frequency modes; in frequency mode only bit 4's waveform toggles.
// - auto-lock holds hold_refresh set until all enabled match buffers are filled.
// - after auto-unlock the lock stays clear until UPDATE, which copies and relocks.
// - with auto-lock off, only software writes change hold_refresh.
// - waveform_kind 0,1,3,5,6,7 are normal, frequency, single and dual slope.
// - top is match 0 in frequency mode, else cycle length; update at top upward.
// - dual-slope modes update at bottom; wrap at bottom, top or both per mode.
// - normal mode generates no waveform on any channel.
// - buffered registers load on UPDATE only while hold_refresh is clear.
// - buffer writes set the filled flag; UPDATE clears all filled flags.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tnmc_defs.vh"
module tnmc_timer (
   input wire mclk,
   input wire rst,
   input wire standby,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [2:0] port_out,
   output reg [2:0] pin_out,
   output wire irq
);
// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] main_ctrl;
reg [7:0] wave_ctrl;
reg [7:0] ovr_val;
reg [7:0] split_sel;
reg [7:0] ev_ctrl;
reg [7:0] irq_en;
reg [7:0] irq_flags;
reg [7:0] dbg_ctrl;
reg [7:0] temp_byte;
reg [15:0] count_value;
reg [15:0] cycle_length;
reg [15:0] length_buffer;
reg [15:0] match_value [0:2];
reg [15:0] match_buffer [0:2];
reg [2:0] match_buffer_filled;
reg length_buffer_filled;
reg hold_refresh;
reg count_down;
reg [3:0] irq_stat;
reg [3:0] irq_mask;
reg [9:0] pre_cnt;
reg [2:0] wave_out;
wire [2:0] wave_hit;
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
wire [2:0] waveform_kind = wave_ctrl[2:0];
wire auto_hold_refresh = wave_ctrl[`TNMC_BIT_AUTOLOCK];
wire [2:0] waveform_pin_override = wave_ctrl[6:4];
wire [2:0] prescale_select = main_ctrl[3:1];
// ----------------------------------------
// decode helpers
// ----------------------------------------
function [9:0] div_mask;
   input [2:0] sel;
   begin
      case (sel)
         3'h0: div_mask = 10'h000;
         3'h1: div_mask = 10'h001;
         3'h2: div_mask = 10'h003;
         3'h3: div_mask = 10'h007;
         3'h4: div_mask = 10'h00f;
         3'h5: div_mask = 10'h03f;
         3'h6: div_mask = 10'h0ff;
         default: div_mask = 10'h3ff;
      endcase
   end
endfunction
function is_dual;
   input [2:0] m;
   begin
      is_dual = (m == `TNMC_WG_DS_TOP) || (m == `TNMC_WG_DS_BOTH) || (m == `TNMC_WG_DS_BOT);
   end
endfunction
// ----------------------------------------
// count tick and sequence
// ----------------------------------------
wire running = main_ctrl[`TNMC_BIT_ENABLE] && (!standby || main_ctrl[`TNMC_BIT_STDBY]);
wire tick = running && ((pre_cnt & div_mask(prescale_select)) == div_mask(prescale_select));
wire [15:0] top_value = (waveform_kind == `TNMC_WG_FREQ) ? match_value[0] : cycle_length;
wire at_top = (count_value >= top_value);
wire at_bottom = (count_value == `TNMC_RST_WORD);
wire up_wrap = tick && !count_down && at_top;
wire down_wrap = tick && count_down && at_bottom;
wire single = (waveform_kind == `TNMC_WG_SINGLE);
wire dual = is_dual(waveform_kind);
wire top_hit = dual && tick && !count_down && at_top;
wire bot_hit = dual && down_wrap;
reg upd_evt;
reg wrap_event;
always @* begin
   upd_evt = 1'b0;
   wrap_event = 1'b0;
   case (waveform_kind)
      `TNMC_WG_NORMAL, `TNMC_WG_FREQ: begin
         upd_evt = up_wrap;
         wrap_event = up_wrap || down_wrap;
      end
      `TNMC_WG_SINGLE: begin
         upd_evt = up_wrap;
         wrap_event = up_wrap;
      end
      `TNMC_WG_DS_TOP: begin
         upd_evt = bot_hit;
         wrap_event = top_hit;
      end
      `TNMC_WG_DS_BOTH: begin
         upd_evt = bot_hit;
         wrap_event = top_hit || bot_hit;
      end
      `TNMC_WG_DS_BOT: begin
         upd_evt = bot_hit;
         wrap_event = bot_hit;
      end
      default: begin
         upd_evt = 1'b0;
         wrap_event = 1'b0;
      end
   endcase
end
// ----------------------------------------
// bus write capture
// ----------------------------------------
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;
wire aw_go = aw_held || (s_axi_awvalid && s_axi_awready);
wire w_go = w_held || (s_axi_wvalid && s_axi_wready);
wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
wire [31:0] wd = w_held ? w_data : s_axi_wdata;
wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
wire wr_do = aw_go && w_go && !s_axi_bvalid;
wire [7:0] wb0 = wd[7:0];
wire [15:0] wword = {ws[1] ? wd[15:8] : 8'h00, ws[0] ? wd[7:0] : 8'h00};
wire wr_lo = wr_do && ws[0] && (wa[1:0] == 2'h0);
wire [5:0] widx = wa[7:2];
function hit;
   input [5:0] idx;
   input [7:0] ref_idx;
   begin
      hit = (idx == ref_idx[5:0]);
   end
endfunction
function valid_addr;
   input [5:0] idx;
   begin
      case (idx)
         6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h09, 6'h0a, 6'h0b,
         6'h0e, 6'h0f, 6'h20, 6'h26, 6'h28, 6'h2a, 6'h2c, 6'h36, 6'h38, 6'h3a, 6'h3c,
         6'h10, 6'h11, 6'h12: valid_addr = 1'b1;
         default: valid_addr = 1'b0;
      endcase
   end
endfunction
wire w_cmd_set = wr_lo && hit(widx, `TNMC_IDX_CMD_SET);
wire w_cmd_clr = wr_lo && hit(widx, `TNMC_IDX_CMD_CLR);
wire force_upd = w_cmd_set && (wb0[3:2] == `TNMC_CMD_UPDATE);
wire force_restart = w_cmd_set && (wb0[3:2] == `TNMC_CMD_RESTART);
wire force_reset = w_cmd_set && (wb0[3:2] == `TNMC_CMD_RESET) && !main_ctrl[`TNMC_BIT_ENABLE];
wire update_now = upd_evt || force_upd;
wire do_load = update_now && !hold_refresh;
wire all_filled = &(match_buffer_filled | ~waveform_pin_override);
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= `TNMC_RST_BYTE;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
   end else begin
      if (s_axi_awvalid && s_axi_awready && !wr_do) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_do) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= valid_addr(widx) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end
end
// ----------------------------------------
// register file and counter
// ----------------------------------------
integer i;
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      main_ctrl <= `TNMC_RST_BYTE;
      wave_ctrl <= `TNMC_RST_BYTE;
      ovr_val <= `TNMC_RST_BYTE;
      split_sel <= `TNMC_RST_BYTE;
      ev_ctrl <= `TNMC_RST_BYTE;
      irq_en <= `TNMC_RST_BYTE;
      irq_flags <= `TNMC_RST_BYTE;
      dbg_ctrl <= `TNMC_RST_BYTE;
      temp_byte <= `TNMC_RST_BYTE;
      count_value <= `TNMC_RST_WORD;
      cycle_length <= `TNMC_RST_PER;
      length_buffer <= `TNMC_RST_WORD;
      for (i = 0; i < 3; i = i + 1) begin
         match_value[i] <= `TNMC_RST_WORD;
         match_buffer[i] <= `TNMC_RST_WORD;
      end
      match_buffer_filled <= 3'h0;
      length_buffer_filled <= 1'b0;
      hold_refresh <= 1'b0;
      count_down <= 1'b0;
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      pre_cnt <= 10'h000;
   end else begin
      pre_cnt <= running ? pre_cnt + 10'h001 : 10'h000;
      if (tick) begin
         if (dual) begin
            if (!count_down && at_top) begin
               count_down <= 1'b1;
               count_value <= count_value - 16'h0001;
            end else if (count_down && at_bottom) begin
               count_down <= 1'b0;
               count_value <= count_value + 16'h0001;
            end else begin
               count_value <= count_down ? count_value - 16'h0001 : count_value + 16'h0001;
            end
         end else if (!count_down) begin
            count_value <= at_top ? `TNMC_RST_WORD : count_value + 16'h0001;
         end else begin
            count_value <= at_bottom ? top_value : count_value - 16'h0001;
         end
      end
      if (do_load) begin
         cycle_length <= length_buffer_filled ? length_buffer : cycle_length;
         for (i = 0; i < 3; i = i + 1) begin
            if (match_buffer_filled[i]) begin
               match_value[i] <= match_buffer[i];
            end
         end
      end
      if (update_now) begin
         match_buffer_filled <= 3'h0;
         length_buffer_filled <= 1'b0;
      end
      if (auto_hold_refresh) begin
         if (update_now) begin
            hold_refresh <= 1'b1;
         end else if (hold_refresh && all_filled) begin
            hold_refresh <= 1'b0;
         end
      end else if (wr_lo && hit(widx, `TNMC_IDX_WAVE_CTRL) && wb0[`TNMC_BIT_AUTOLOCK]) begin
         hold_refresh <= 1'b1;
      end
      // hold_refresh changes only by writes when auto-lock is off
      if (w_cmd_set && wb0[`TNMC_BIT_LOCK]) begin
         hold_refresh <= 1'b1;
      end
      if (w_cmd_clr && wb0[`TNMC_BIT_LOCK]) begin
         hold_refresh <= 1'b0;
      end
      if (w_cmd_set && wb0[`TNMC_BIT_DIR]) begin
         count_down <= 1'b1;
      end
      if (w_cmd_clr && wb0[`TNMC_BIT_DIR]) begin
         count_down <= 1'b0;
      end
      if (force_restart) begin
         count_value <= `TNMC_RST_WORD;
         count_down <= 1'b0;
      end
      if (force_reset) begin
         count_value <= `TNMC_RST_WORD;
         count_down <= 1'b0;
         hold_refresh <= 1'b0;
      end
      if (wr_lo) begin
         if (hit(widx, `TNMC_IDX_MAIN_CTRL)) main_ctrl <= wb0 & 8'h8f;
         if (hit(widx, `TNMC_IDX_WAVE_CTRL)) wave_ctrl <= wb0 & 8'h7f;
         if (hit(widx, `TNMC_IDX_OVR_VAL)) ovr_val <= wb0 & 8'h07;
         if (hit(widx, `TNMC_IDX_SPLIT)) split_sel <= wb0 & 8'h01;
         if (hit(widx, `TNMC_IDX_EV_CTRL)) ev_ctrl <= wb0;
         if (hit(widx, `TNMC_IDX_IRQ_EN)) irq_en <= wb0 & 8'h71;
         if (hit(widx, `TNMC_IDX_DBG)) dbg_ctrl <= wb0 & 8'h01;
         if (hit(widx, `TNMC_IDX_TEMP)) temp_byte <= wb0;
         if (hit(widx, `TNMC_IDX_IRQ_MASK)) irq_mask <= wb0[3:0];
         if (hit(widx, `TNMC_IDX_CNT)) count_value <= wword;
         if (hit(widx, `TNMC_IDX_PER)) cycle_length <= wword;
         if (hit(widx, `TNMC_IDX_CYCLE_LENGTH_BUFFER)) length_buffer <= wword;
         if (hit(widx, `TNMC_IDX_BV_CLR)) begin
            length_buffer_filled <= length_buffer_filled & ~wb0[0];
            match_buffer_filled <= match_buffer_filled & ~wb0[3:1];
         end
      end
      if (wr_lo && hit(widx, `TNMC_IDX_CYCLE_LENGTH_BUFFER)) length_buffer_filled <= 1'b1;
      if (wr_lo && hit(widx, `TNMC_IDX_BV_SET)) begin
         length_buffer_filled <= length_buffer_filled | wb0[0];
         match_buffer_filled <= match_buffer_filled | wb0[3:1];
      end
      for (i = 0; i < 3; i = i + 1) begin
         if (wr_lo && (widx == `TNMC_IDX_MATCH_VALUE_0 + 2 * i)) match_value[i] <= wword;
         if (wr_lo && (widx == `TNMC_IDX_CMPBUF0 + 2 * i)) begin
            match_buffer[i] <= wword;
            match_buffer_filled[i] <= 1'b1;
         end
      end
      // events win over software clears
      irq_flags <= (wr_lo && hit(widx, `TNMC_IDX_IRQ_FLAGS)) ? irq_flags & ~(wb0 & 8'h71) : irq_flags;
      irq_stat <= ((wr_lo && hit(widx, `TNMC_IDX_IRQ_CLR)) ? irq_stat & ~wb0[3:0] : irq_stat)
         | {wave_hit, wrap_event};
      if (wrap_event) irq_flags[0] <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         if (wave_hit[i]) irq_flags[4 + i] <= 1'b1;
      end
   end
end
// ----------------------------------------
// compare matches and waveform
// ----------------------------------------
genvar g;
generate
   for (g = 0; g < 3; g = g + 1) begin : chan
      assign wave_hit[g] = tick && (count_value == match_value[g]);
      always @(posedge mclk or posedge rst) begin
         if (rst) begin
            wave_out[g] <= 1'b0;
         end else if (!main_ctrl[`TNMC_BIT_ENABLE]) begin
            wave_out[g] <= ovr_val[g];
         end else if (waveform_kind == `TNMC_WG_FREQ) begin
            if (g == 0 && up_wrap) wave_out[g] <= ~wave_out[g];
         end else if (single) begin
            if (up_wrap) wave_out[g] <= 1'b1;
            else if (wave_hit[g]) wave_out[g] <= 1'b0;
         end else if (dual) begin
            if (wave_hit[g]) wave_out[g] <= count_down;
         end
      end
      always @(posedge mclk or posedge rst) begin
         if (rst) begin
            pin_out[g] <= 1'b0;
         end else if (waveform_kind != `TNMC_WG_NORMAL && waveform_pin_override[g]) begin
            pin_out[g] <= wave_out[g];
         end else begin
            pin_out[g] <= port_out[g];
         end
      end
   end
endgenerate
assign irq = |(irq_stat & irq_mask);
// ----------------------------------------
// bus read
// ----------------------------------------
assign s_axi_arready = !s_axi_rvalid;
wire [5:0] ridx = s_axi_araddr[7:2];
reg [15:0] rd;
always @* begin
   rd = 16'h0000;
   case (ridx)
      6'h00: rd = {8'h00, main_ctrl};
      6'h01: rd = {8'h00, wave_ctrl};
      6'h02: rd = {8'h00, ovr_val};
      6'h03: rd = {8'h00, split_sel};
      6'h04, 6'h05: rd = {14'h0000, hold_refresh, count_down};
      6'h06, 6'h07: rd = {12'h000, match_buffer_filled, length_buffer_filled};
      6'h09: rd = {8'h00, ev_ctrl};
      6'h0a: rd = {8'h00, irq_en};
      6'h0b: rd = {8'h00, irq_flags};
      6'h0e: rd = {8'h00, dbg_ctrl};
      6'h0f: rd = {8'h00, temp_byte};
      6'h20: rd = count_value;
      6'h26: rd = cycle_length;
      6'h28: rd = match_value[0];
      6'h2a: rd = match_value[1];
      6'h2c: rd = match_value[2];
      6'h36: rd = length_buffer;
      6'h38: rd = match_buffer[0];
      6'h3a: rd = match_buffer[1];
      6'h3c: rd = match_buffer[2];
      6'h10: rd = {12'h000, irq_stat};
      6'h12: rd = {12'h000, irq_mask};
      default: rd = 16'h0000;
   endcase
end
always @(posedge mclk or posedge rst) begin
   if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
   end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd};
      s_axi_rresp <= valid_addr(ridx) ? 2'h0 : 2'h2;
   end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
   end
end
endmodule

// ==== common/tnmc_defs.vh ====
`ifndef TNMC_DEFS_VH
`define TNMC_DEFS_VH
// ----------------------------------------
// register indices (byte address / 4)
// ----------------------------------------
`define TNMC_IDX_MAIN_CTRL 8'h00
`define TNMC_IDX_WAVE_CTRL 8'h01
`define TNMC_IDX_OVR_VAL 8'h02
`define TNMC_IDX_SPLIT 8'h03
`define TNMC_IDX_CMD_CLR 8'h04
`define TNMC_IDX_CMD_SET 8'h05
`define TNMC_IDX_BV_CLR 8'h06
`define TNMC_IDX_BV_SET 8'h07
`define TNMC_IDX_EV_CTRL 8'h09
`define TNMC_IDX_IRQ_EN 8'h0a
`define TNMC_IDX_IRQ_FLAGS 8'h0b
`define TNMC_IDX_DBG 8'h0e
`define TNMC_IDX_TEMP 8'h0f
`define TNMC_IDX_CNT 8'h20
`define TNMC_IDX_PER 8'h26
`define TNMC_IDX_MATCH_VALUE_0 8'h28
`define TNMC_IDX_MATCH_VALUE_1 8'h2a
`define TNMC_IDX_MATCH_VALUE_2 8'h2c
`define TNMC_IDX_CYCLE_LENGTH_BUFFER 8'h36
`define TNMC_IDX_CMPBUF0 8'h38
`define TNMC_IDX_CMPBUF1 8'h3a
`define TNMC_IDX_CMPBUF2 8'h3c
`define TNMC_IDX_IRQ_STAT 8'h10
`define TNMC_IDX_IRQ_CLR 8'h11
`define TNMC_IDX_IRQ_MASK 8'h12
// ----------------------------------------
// field positions
// ----------------------------------------
`define TNMC_BIT_ENABLE 0
`define TNMC_BIT_STDBY 7
`define TNMC_BIT_AUTOLOCK 3
`define TNMC_BIT_OVR0 4
`define TNMC_BIT_LOCK 1
`define TNMC_BIT_DIR 0
// ----------------------------------------
// modes and reset values
// ----------------------------------------
`define TNMC_WG_NORMAL 3'h0
`define TNMC_WG_FREQ 3'h1
`define TNMC_WG_SINGLE 3'h3
`define TNMC_WG_DS_TOP 3'h5
`define TNMC_WG_DS_BOTH 3'h6
`define TNMC_WG_DS_BOT 3'h7
`define TNMC_CMD_UPDATE 2'h1
`define TNMC_CMD_RESTART 2'h2
`define TNMC_CMD_RESET 2'h3
`define TNMC_RST_BYTE 8'h00
`define TNMC_RST_WORD 16'h0000
`define TNMC_RST_PER 16'hffff
`endif

// ==== verif/tnmc_timer_sva.sv ====
`timescale 1ns/1ns
module tnmc_timer_sva (
   input wire mclk,
   input wire rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [2:0] port_out,
   input wire [2:0] pin_out,
   input wire irq
);
   // ----------------------------------------
   // shadows of waveform control and irq mask
   // ----------------------------------------
   reg [7:0] wave_sh;
   reg [3:0] mask_sh;
   wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire [2:0] pin_mask = (wave_sh[2:0] != 3'h0) ? wave_sh[6:4] : 3'h0;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         wave_sh <= 8'h00;
         mask_sh <= 4'h0;
      end else if (wr_go) begin
         if (s_axi_awaddr == 8'h04) wave_sh <= s_axi_wdata[7:0];
         if (s_axi_awaddr == 8'h48) mask_sh <= s_axi_wdata[3:0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   a_write_answer: assert property (wr_go |=> s_axi_bvalid)
      else $error("write response missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_read_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_write_gate: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
      else $error("write taken while answer pending");
   a_bad_index: assert property (wr_go && s_axi_awaddr == 8'h20 |=> s_axi_bresp == 2'h2)
      else $error("unmapped write not refused");
   a_pin_follow: assert property (1'b1 |=> ((pin_out ^ $past(port_out)) & ~$past(pin_mask)) == 3'h0)
      else $error("pin does not follow port value");
   a_irq_masked: assert property (mask_sh == 4'h0 |-> !irq)
      else $error("interrupt raised while masked");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_override: cover property (pin_mask != 3'h0);
   c_irq: cover property (irq);
endmodule
bind tnmc_timer tnmc_timer_sva chk_u (.mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .port_out(port_out),
   .pin_out(pin_out), .irq(irq));

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench;
   localparam [7:0] A_MAIN = 8'h00, A_WAVE = 8'h04, A_OVR = 8'h08, A_DCLR = 8'h10, A_DSET = 8'h14;
   localparam [7:0] A_BVCLR = 8'h18, A_BVSET = 8'h1c, A_CNT = 8'h80, A_PER = 8'h98, A_MATCH_VALUE_0 = 8'ha0;
   localparam [7:0] A_CBUF0 = 8'he0, A_STAT = 8'h40, A_CLR = 8'h44, A_MASK = 8'h48;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg standby = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg s_axi_awvalid = 1'b0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg [7:0] s_axi_araddr = 8'h00;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   reg [2:0] port_out = 3'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0] pin_out;
   reg [1:0] wresp, rrsp;
   reg [31:0] rdat;
   integer num_errors = 0;
   integer samples_checked = 0;
   tnmc_timer dut_u (.mclk(mclk), .rst(rst), .standby(standby), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .port_out(port_out), .pin_out(pin_out), .irq(irq));
   initial begin
      forever #25 mclk = ~mclk;
   end
   // ----------------------------------------
   // bus and compare helpers
   // ----------------------------------------
   task cyc(input integer n);
      begin
         repeat (n) @(posedge mclk);
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      reg done;
      begin
         done = 1'b0;
         @(posedge mclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         while (!done) begin
            @(posedge mclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               wresp = s_axi_bresp;
               s_axi_bready <= 1'b0;
               done = 1'b1;
            end
         end
      end
   endtask
   task rd(input [7:0] a);
      reg done;
      begin
         done = 1'b0;
         @(posedge mclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         while (!done) begin
            @(posedge mclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
               rdat = s_axi_rdata;
               rrsp = s_axi_rresp;
               s_axi_rready <= 1'b0;
               done = 1'b1;
            end
         end
      end
   endtask
   task rchk(input [7:0] a, input [31:0] e);
      begin
         rd(a);
         check(rdat, e);
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      begin
         rchk(A_MAIN, 32'h0);
         rchk(A_WAVE, 32'h0);
         rchk(A_PER, 32'hffff);
         rchk(A_STAT, 32'h0);
         wr(8'h20, 32'h5);
         check({30'h0, wresp}, 32'h2);
         rd(8'h20);
         check({30'h0, rrsp}, 32'h2);
         check(rdat, 32'h0);
      end
   endtask
   task t_prescale;
      integer k;
      reg [31:0] c;
      begin
         for (k = 0; k < 8; k = k + 1) begin
            wr(A_CNT, 32'h0);
            wr(A_MAIN, {28'h0, k[2:0], 1'b1});
            cyc(16 * ((k < 5) ? (1 << k) : (16 << (2 * (k - 4)))));
            wr(A_MAIN, {28'h0, k[2:0], 1'b0});
            rd(A_CNT);
            c = rdat;
            check({31'h0, (c >= 15) && (c <= 20)}, 32'h1);
            cyc(20);
            rchk(A_CNT, c);
         end
      end
   endtask
   task t_standby;
      begin
         wr(A_CNT, 32'h0);
         standby <= 1'b1;
         wr(A_MAIN, 32'h1);
         cyc(50);
         wr(A_MAIN, 32'h0);
         rchk(A_CNT, 32'h0);
         wr(A_MAIN, 32'h81);
         cyc(50);
         wr(A_MAIN, 32'h80);
         rd(A_CNT);
         check({31'h0, (rdat >= 50) && (rdat <= 55)}, 32'h1);
         standby <= 1'b0;
      end
   endtask
   task t_top;
      begin
         wr(A_MATCH_VALUE_0, 32'h3);
         wr(A_CNT, 32'h0);
         wr(A_WAVE, 32'h1);
         wr(A_CLR, 32'hf);
         wr(A_MAIN, 32'h1);
         cyc(30);
         wr(A_MAIN, 32'h0);
         rd(A_CNT);
         check({31'h0, rdat <= 3}, 32'h1);
         rd(A_STAT);
         check({31'h0, rdat[0]}, 32'h1);
         wr(A_WAVE, 32'h0);
         wr(A_CNT, 32'h0);
         wr(A_MAIN, 32'h1);
         cyc(30);
         wr(A_MAIN, 32'h0);
         rd(A_CNT);
         check({31'h0, rdat > 3}, 32'h1);
      end
   endtask
   task t_modes;
      integer i;
      reg [2:0] m;
      begin
         wr(A_PER, 32'd100);
         wr(A_MASK, 32'h1);
         for (i = 0; i < 4; i = i + 1) begin
            m = (i == 0) ? 3'h3 : 3'h4 + i[2:0];
            wr(A_MAIN, 32'h0);
            wr(A_CNT, 32'h0);
            wr(A_DCLR, 32'h1);
            wr(A_WAVE, {29'h0, m});
            wr(A_MAIN, 32'h1);
            cyc(20);
            wr(A_CLR, 32'hf);
            cyc(100);
            rd(A_STAT);
            check({31'h0, rdat[0]}, {31'h0, m != 3'h7});
            check({31'h0, irq}, {31'h0, m != 3'h7});
            rd(A_DCLR);
            check({31'h0, rdat[0]}, {31'h0, m != 3'h3});
         end
         wr(A_MAIN, 32'h0);
         wr(A_CLR, 32'hf);
         check({31'h0, irq}, 32'h0);
      end
   endtask
   task t_buffers;
      begin
         wr(A_WAVE, 32'h0);
         wr(A_DCLR, 32'h1);
         wr(A_BVCLR, 32'hf);
         wr(A_CBUF0, 32'h1234);
         rchk(A_BVSET, 32'h2);
         wr(A_DSET, 32'h4);
         rchk(A_MATCH_VALUE_0, 32'h1234);
         rchk(A_BVSET, 32'h0);
         wr(A_DSET, 32'h2);
         wr(A_CBUF0, 32'h5678);
         wr(A_DSET, 32'h4);
         rchk(A_MATCH_VALUE_0, 32'h1234);
         rchk(A_DSET, 32'h2);
         wr(A_DCLR, 32'h2);
         wr(A_DSET, 32'h4);
         rchk(A_DSET, 32'h0);
         wr(A_BVCLR, 32'hf);
         wr(A_WAVE, 32'h1b);
         rchk(A_DSET, 32'h2);
         wr(A_CBUF0, 32'h0042);
         rchk(A_DSET, 32'h0);
         cyc(10);
         rchk(A_DSET, 32'h0);
         wr(A_DSET, 32'h4);
         rchk(A_MATCH_VALUE_0, 32'h0042);
         rchk(A_DSET, 32'h2);
      end
   endtask
   task t_pins;
      begin
         port_out <= 3'b010;
         wr(A_OVR, 32'h1);
         wr(A_WAVE, 32'h11);
         cyc(3);
         check({29'h0, pin_out}, 32'h3);
         wr(A_WAVE, 32'h70);
         cyc(3);
         check({29'h0, pin_out}, 32'h2);
         wr(A_WAVE, 32'h71);
         cyc(3);
         check({29'h0, pin_out}, 32'h1);
      end
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task results;
      begin
         $display("checks %0d errors %0d", samples_checked, num_errors);
         if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      num_errors = num_errors + 1;
      results;
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_prescale;
      t_standby;
      t_top;
      t_modes;
      t_buffers;
      t_pins;
      results;
   end
endmodule
